// ==== hw/eiec_top.v ====
// External interrupt clock gating and external interrupt 1 edge detection
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps

`include "eiec_defs.vh"

module eiec_top #(
  parameter NC_AGREE = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire [`EIEC_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`EIEC_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire low_speed_mode,
  input wire low_frequency_tick,
  input wire ext1_pin,
  output reg [`EIEC_SRC_N-1:0] ext_source_clock_enable,
  output reg ext1_request
);

  // ****************************************
  // Register state
  // ****************************************
  reg [1:0] ext1_edge_select;
  reg [1:0] ext1_filter_interval;
  reg ext1_captured_level;
  wire ext1_clock_enable;

  assign ext1_clock_enable = ext_source_clock_enable[`EIEC_EXT1_BIT];

  // ****************************************
  // Write channel
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [`EIEC_ADDR_W-1:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane;
  wire wr_fire;
  wire [`EIEC_ADDR_W-1:0] wr_addr;
  wire [7:0] wr_byte;
  wire wr_lane;
  wire wr_store;

  // Address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
  assign wr_lane = w_held ? w_lane : s_axi_wstrb[0];
  assign wr_fire = !s_axi_bvalid && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);
  // Lane 0 clear: the write is answered but stores nothing
  assign wr_store = wr_fire && wr_lane;

  // ****************************************
  // Address decode
  // ****************************************
  // Full 16-bit match, so aliases of a register answer as unmapped
  wire wr_hit_pgr;
  wire wr_hit_ctl;
  wire rd_hit_pgr;
  wire rd_hit_ctl;

  assign wr_hit_pgr = (wr_addr == `EIEC_PGR_ADDR);
  assign wr_hit_ctl = (wr_addr == `EIEC_CTL_ADDR);
  assign rd_hit_pgr = (s_axi_araddr == `EIEC_PGR_ADDR);
  assign rd_hit_ctl = (s_axi_araddr == `EIEC_CTL_ADDR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`EIEC_ADDR_W{1'b0}};
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EIEC_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_hit_pgr || wr_hit_ctl) begin
          s_axi_bresp <= `EIEC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `EIEC_RESP_SLVERR;
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_byte <= s_axi_wdata[7:0];
          w_lane <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Only byte lane 0 carries register bits; other lanes are ignored
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_source_clock_enable <= `EIEC_EN_RESET;
      ext1_edge_select <= `EIEC_ES_RESET;
      ext1_filter_interval <= `EIEC_NC_RESET;
    end else if (wr_store) begin
      // The enable register stays writable so software can restart a stopped circuit
      if (wr_hit_pgr) begin
        ext_source_clock_enable <= wr_byte[`EIEC_SRC_N-1:0];
      end else if (wr_hit_ctl) begin
        // A stopped circuit has no clock to take the write
        if (ext1_clock_enable) begin
          ext1_edge_select <= wr_byte[`EIEC_ES_MSB:`EIEC_ES_LSB];
          ext1_filter_interval <= wr_byte[`EIEC_NC_MSB:`EIEC_NC_LSB];
        end
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  // Reads have no side effects; the captured level is held, not cleared
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `EIEC_DATA_ZERO;
      s_axi_rresp <= `EIEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (rd_hit_pgr) begin
        s_axi_rdata <= {`EIEC_PGR_PAD, ext_source_clock_enable};
        s_axi_rresp <= `EIEC_RESP_OKAY;
      end else if (rd_hit_ctl) begin
        s_axi_rdata <= {`EIEC_CTL_PAD, ext1_captured_level,
                        ext1_edge_select, ext1_filter_interval};
        s_axi_rresp <= `EIEC_RESP_OKAY;
      end else begin
        s_axi_rdata <= `EIEC_DATA_ZERO;
        s_axi_rresp <= `EIEC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  reg pin_meta;
  reg pin_s2;
  reg pin_s3;
  reg pin_level;

  // A change counts only once the second and third stages agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pin_meta <= ext1_pin;
      pin_s2 <= pin_meta;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // ****************************************
  // Sample clock
  // ****************************************
  reg [3:0] prescale;
  reg [1:0] lf_count;
  reg [3:0] term;
  reg sample_tick;
  wire lf_sample;
  wire prescale_done;

  assign lf_sample = low_frequency_tick && (lf_count == `EIEC_LF_TERM);
  assign prescale_done = (prescale >= term);

  always @* begin
    case (ext1_filter_interval)
      `EIEC_NC_DIV4: term = `EIEC_TERM_DIV4;
      `EIEC_NC_DIV8: term = `EIEC_TERM_DIV8;
      `EIEC_NC_DIV16: term = `EIEC_TERM_DIV16;
      default: term = 4'h0;
    endcase
  end

  always @* begin
    if (!ext1_clock_enable) begin
      sample_tick = 1'b0;
    end else if (low_speed_mode) begin
      sample_tick = lf_sample;
    end else begin
      sample_tick = prescale_done;
    end
  end

  // Divider restarts on a mode swap so the first interval is never short
  reg mode_seen;
  wire mode_swap;

  assign mode_swap = (mode_seen != low_speed_mode);

  always @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 4'h0;
      lf_count <= 2'h0;
      mode_seen <= 1'b0;
    end else if (!ext1_clock_enable) begin
      prescale <= prescale;
      lf_count <= lf_count;
      mode_seen <= mode_seen;
    end else begin
      mode_seen <= low_speed_mode;
      if (mode_swap) begin
        prescale <= 4'h0;
        lf_count <= 2'h0;
      end else if (low_speed_mode) begin
        if (low_frequency_tick) begin
          lf_count <= lf_count + 2'h1;
        end
      end else if (prescale_done) begin
        prescale <= 4'h0;
      end else begin
        prescale <= prescale + 4'h1;
      end
    end
  end

  // ****************************************
  // Noise canceller
  // ****************************************
  // Level must differ on NC_AGREE samples in a row before it passes
  reg ext1_filtered;
  reg [1:0] nc_count;
  // NC_AGREE above 4 would overflow the two-bit run counter
  localparam [31:0] NC_LAST_FULL = NC_AGREE - 1;
  localparam [1:0] NC_LAST = NC_LAST_FULL[1:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext1_filtered <= 1'b0;
      nc_count <= 2'h0;
    end else if (sample_tick) begin
      if (pin_level == ext1_filtered) begin
        nc_count <= 2'h0;
      end else if (nc_count == NC_LAST) begin
        ext1_filtered <= pin_level;
        nc_count <= 2'h0;
      end else begin
        nc_count <= nc_count + 2'h1;
      end
    end
  end

  // ****************************************
  // Edge detection and request
  // ****************************************
  reg filt_prev;
  reg next_request;
  wire rise_seen;
  wire fall_seen;

  // Edges come from the filtered level only, never the raw pin
  assign rise_seen = ext1_filtered && !filt_prev;
  assign fall_seen = !ext1_filtered && filt_prev;

  always @* begin
    case (ext1_edge_select)
      `EIEC_ES_RISE: next_request = rise_seen;
      `EIEC_ES_FALL: next_request = fall_seen;
      `EIEC_ES_BOTH: next_request = rise_seen || fall_seen;
      default: next_request = 1'b0;
    endcase
  end

  // Filtered level freezes with the stopped circuit; the request is held clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      filt_prev <= 1'b0;
      ext1_request <= 1'b0;
      ext1_captured_level <= 1'b0;
    end else if (!ext1_clock_enable) begin
      ext1_request <= 1'b0;
    end else begin
      filt_prev <= ext1_filtered;
      ext1_request <= next_request;
      if (next_request) begin
        ext1_captured_level <= ext1_filtered;
      end
    end
  end

endmodule

// ==== hw/eiec_defs.vh ====
// Constants for the external interrupt edge control block
`ifndef EIEC_DEFS_VH
`define EIEC_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define EIEC_ADDR_W 16
`define EIEC_PGR_INDEX 14'h0F77
`define EIEC_CTL_INDEX 14'h0FD8
`define EIEC_PGR_ADDR {`EIEC_PGR_INDEX, 2'h0}
`define EIEC_CTL_ADDR {`EIEC_CTL_INDEX, 2'h0}

// ****************************************
// Fields and reset values
// ****************************************
`define EIEC_SRC_N 6
`define EIEC_EN_RESET 6'h00
`define EIEC_EXT1_BIT 1
`define EIEC_ES_RESET 2'h0
`define EIEC_NC_RESET 2'h0
`define EIEC_PGR_PAD 26'h0000000
`define EIEC_CTL_PAD 27'h0000000
`define EIEC_ES_MSB 3
`define EIEC_ES_LSB 2
`define EIEC_NC_MSB 1
`define EIEC_NC_LSB 0
`define EIEC_DATA_ZERO 32'h00000000

// ****************************************
// Edge select codes
// ****************************************
`define EIEC_ES_RISE 2'h0
`define EIEC_ES_FALL 2'h1
`define EIEC_ES_BOTH 2'h2

// ****************************************
// Sampling intervals
// ****************************************
`define EIEC_NC_DIV1 2'h0
`define EIEC_NC_DIV4 2'h1
`define EIEC_NC_DIV8 2'h2
`define EIEC_NC_DIV16 2'h3
`define EIEC_TERM_DIV4 4'h3
`define EIEC_TERM_DIV8 4'h7
`define EIEC_TERM_DIV16 4'hF
`define EIEC_LF_TERM 2'h3

// ****************************************
// Bus answers
// ****************************************
`define EIEC_RESP_OKAY 2'h0
`define EIEC_RESP_SLVERR 2'h2

`endif

// ==== dv/eiec_pin_model.sv ====
// Partner model of the external interrupt 1 input pin
`timescale 1ns/10ps
module eiec_pin_model (
  input wire aclk,
  input wire level,
  input wire glitch,
  output logic ext1_pin
);
  logic last = 1'b0;
  logic [1:0] bounce = 2'h0;
  // Contact bounce after each change, so the filter sees runs shorter than its count
  always @(posedge aclk) begin
    last <= level;
    bounce <= (level != last) ? 2'h3 : ((bounce == 2'h0) ? 2'h0 : bounce - 2'h1);
  end
  assign ext1_pin = glitch ^ (bounce[0] ? ~level : level);
endmodule

// ==== dv/eiec_chk_props.sv ====
// Port checks for the external interrupt edge control block
`timescale 1ns/10ps
`include "eiec_defs.vh"
module eiec_chk #(
  parameter NC_AGREE = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire [5:0] ext_source_clock_enable,
  input wire ext1_request
);
  // ********
  // Checks
  // ********
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_req_pulse:
    assert property (ext1_request |=> !ext1_request) else $error("request too long");
  chk_gate_stop:
    assert property (!ext_source_clock_enable[1] && !$past(ext_source_clock_enable[1])
      |-> !ext1_request) else $error("request while stopped");
  chk_read_pad:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("pad bits set");
  chk_reset_clear:
    assert property ($rose(aresetn) |-> ext_source_clock_enable == 6'h00 && !ext1_request)
      else $error("reset values wrong");
  chk_enable_write:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_wstrb[0] && s_axi_awaddr == `EIEC_PGR_ADDR
      |=> ext_source_clock_enable == $past(s_axi_wdata[5:0])) else $error("enable not written");
  chk_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("no write answer");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  chk_write_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  chk_read_refuse:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken");
endmodule
bind eiec_top eiec_chk #(.NC_AGREE(NC_AGREE)) eiec_chk_inst (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .ext_source_clock_enable, .ext1_request);

// ==== dv/tb.sv ====
// Self-checking bench for the external interrupt edge control block
`timescale 1ns/10ps
`include "eiec_defs.vh"
module tb;
  localparam int AGREE = 3;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lsm, tick, level, glitch;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, seed, v, rd_data;
  logic [1:0] rd_resp;
  wire awready, wready, bvalid, arready, rvalid, req, pin;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] en;
  int fails, tests_run, reqs, cyc, req_at, tcnt, n0, t0, es, nc, d, lvl, m_en, m_ctl;
  eiec_top #(.NC_AGREE(AGREE)) eiec_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .low_speed_mode(lsm), .low_frequency_tick(tick), .ext1_pin(pin),
    .ext_source_clock_enable(en), .ext1_request(req));
  eiec_pin_model eiec_pin_model_inst (.aclk(aclk), .level(level), .glitch(glitch),
    .ext1_pin(pin));
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // Low clock tick every 5 cycles; also counts requests
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
    tick <= (tcnt == 4);
    if (req === 1'b1) begin
      reqs <= reqs + 1;
      req_at <= cyc;
    end
  end
  // ********
  // Tasks
  // ********
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task give_verdict;
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] dat);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 64 && !bvalid; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end
    bready <= 0;
    chk("bresp", bresp, 0);
    if (a == `EIEC_PGR_ADDR) m_en = dat & 32'h3F;
    if (a == `EIEC_CTL_ADDR && m_en[1]) m_ctl = dat & 32'h0F;
    if (n == 64) begin
      fails++;
      give_verdict;
    end
  endtask
  task rd(input logic [15:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 64 && !rvalid; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 0;
    if (a == `EIEC_PGR_ADDR) chk("pgr_model", rd_data, m_en);
    if (a == `EIEC_CTL_ADDR) chk("ctl_model", rd_data, lvl * 16 + m_ctl);
    if (n == 64) begin
      fails++;
      give_verdict;
    end
  endtask
  // ********
  // Scenarios
  // ********
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, lsm, level, glitch} = 0;
    {awaddr, araddr, wdata} = 0;
    {fails, tests_run} = 0;
    seed = 32'h8773;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(`EIEC_PGR_ADDR);
    chk("pgr_reset", rd_data, 0);
    rd(`EIEC_CTL_ADDR);
    chk("ctl_reset", rd_data, 0);
    rd(16'h0100);
    chk("unmapped", rd_resp, 2);
    wr(`EIEC_CTL_ADDR, 32'h0E);
    rd(`EIEC_CTL_ADDR);
    chk("ctl_gated", rd_data, 0);
    v = xs() | 32'h2;
    wr(`EIEC_PGR_ADDR, v);
    rd(`EIEC_PGR_ADDR);
    chk("pgr_rw", rd_data, v & 32'h3F);
    chk("enables", en, v & 32'h3F);
    wr(`EIEC_CTL_ADDR, 32'hFF);
    rd(`EIEC_CTL_ADDR);
    chk("ctl_ro", rd_data, 32'h0F);
    lvl = 0;
    for (es = 0; es < 4; es++) for (nc = 0; nc < 4; nc++) begin
      wr(`EIEC_CTL_ADDR, es * 4 + nc);
      d = (nc == 0) ? 1 : (1 << (nc + 1));
      repeat (150) @(posedge aclk);
      n0 = reqs;
      glitch <= 1;
      repeat (2) @(posedge aclk);
      glitch <= 0;
      repeat (150) @(posedge aclk);
      chk("glitch", reqs - n0, 0);
      t0 = cyc;
      level <= 1;
      repeat (150) @(posedge aclk);
      if (es == 0 || es == 2)
        chk("latency", req_at - t0 >= (AGREE - 1) * d && req_at - t0 <= AGREE * d + 16, 1);
      level <= 0;
      repeat (150) @(posedge aclk);
      chk("requests", reqs - n0, (es == 2) ? 2 : ((es == 3) ? 0 : 1));
      if (es < 3) lvl = (es == 0);
      rd(`EIEC_CTL_ADDR);
      chk("ctl_level", rd_data, lvl * 16 + es * 4 + nc);
    end
    wr(`EIEC_CTL_ADDR, 32'h0);
    lsm <= 1;
    repeat (60) @(posedge aclk);
    n0 = reqs;
    t0 = cyc;
    level <= 1;
    repeat (400) @(posedge aclk);
    chk("slow_latency", req_at - t0 >= (AGREE - 1) * 20 && req_at - t0 <= AGREE * 20 + 25, 1);
    chk("slow_requests", reqs - n0, 1);
    level <= 0;
    repeat (400) @(posedge aclk);
    lsm <= 0;
    repeat (70) @(posedge aclk);
    wr(`EIEC_PGR_ADDR, v & 32'h3D);
    n0 = reqs;
    level <= 1;
    repeat (150) @(posedge aclk);
    level <= 0;
    repeat (150) @(posedge aclk);
    chk("gated_requests", reqs - n0, 0);
    chk("enables_off", en, v & 32'h3D);
    give_verdict;
  end
endmodule
